// >>> test/radio_spi_config_regs_tb.sv
// Self-checking bench for the serial register front end.
// Assumes the host model drives the link at 125 ns per bit.
`timescale 1ns/100ps
module radio_spi_config_regs_tb;
	logic        core_clk, rstn, spi_sck, spi_csn_n, spi_mosi;
	logic        spi_miso, spi_miso_oe, irq_n, bank_indicator;
	logic        crc_enable, crc_length_select, power_on_bit;
	logic        primary_role_select;
	logic [5:0]  auto_ack_pipes, rx_pipe_enables;
	logic [2:0]  ev;
	logic [7:0]  st;
	logic [31:0] rd;
	logic [7:0]  rv [3] = '{8'h08, 8'h3f, 8'h03};
	int          errors, total_checks;
	wire logic   miso_line;
	rscr_spi_regs i_rscr_spi_regs (.core_clk, .rstn, .spi_sck, .spi_csn_n,
		.spi_mosi, .spi_miso, .spi_miso_oe, .irq_n,
		.rx_ready_evt(ev[2]), .tx_sent_evt(ev[1]), .retry_limit_evt(ev[0]),
		.crc_enable, .crc_length_select, .power_on_bit,
		.primary_role_select, .auto_ack_pipes, .rx_pipe_enables,
		.bank_indicator);
	// Released line reads inverted, so a stale bit cannot pass
	assign miso_line = spi_miso_oe ? spi_miso : ~spi_miso;
	rscr_host i_rscr_host (.spi_sck, .spi_csn_n, .spi_mosi,
		.spi_miso(miso_line));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// writes issued in any power state, also while powered up
	// Frame: command, then n bytes, first byte in wd[7:0]
	task automatic acc(input logic [7:0] cmd, input int n,
		input logic [31:0] wd);
		logic [7:0] b;
		i_rscr_host.sel();
		i_rscr_host.xbyte(cmd, st);
		rd = '0;
		for (int k = 0; k < n; k++) begin
			i_rscr_host.xbyte(wd[8*k +: 8], b);
			rd[8*k +: 8] = b;
		end
		i_rscr_host.desel();
	endtask
	task automatic pulse(input int i);
		@(posedge core_clk);
		ev[i] <= 1'b1;
		@(posedge core_clk);
		ev <= '0;
		repeat (3) @(posedge core_clk);
	endtask
	// Tests need about 100 us; allow four times that
	initial begin
		#400000;
		errors++;
		give_verdict();
	end
	initial begin
		rstn = 1'b0;
		ev = '0;
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (10) @(posedge core_clk);
		acc(8'hff, 0, 0);
		check(st, 8'h0e);
		check(spi_miso_oe, 1'b0);
		for (int a = 0; a < 3; a++) begin
			acc(a[7:0], 1, 0);
			check(rd, rv[a]);
		end
		check({crc_enable, crc_length_select, power_on_bit,
			primary_role_select, auto_ack_pipes, rx_pipe_enables},
			16'h8fc3);
		acc(8'h20, 1, 8'hff);
		acc(8'h00, 1, 0);
		check(rd, 8'h7f);
		check({crc_length_select, power_on_bit, primary_role_select},
			3'h7);
		acc(8'h20, 1, 8'h00);
		acc(8'h21, 1, 8'h00);
		check(crc_enable, 1'b0);
		acc(8'h21, 1, 8'h20);
		check(crc_enable, 1'b1);
		acc(8'h21, 1, 8'hff);
		acc(8'h01, 1, 0);
		check(rd, 8'h3f);
		acc(8'h22, 1, 8'hff);
		check(rx_pipe_enables, 6'h3f);
		acc(8'h20, 1, 8'h00);
		for (int i = 0; i < 3; i++) begin
			pulse(i);
			check(irq_n, 1'b0);
			acc(8'h27, 1, 8'h01 << (4 + i));
			check(irq_n, 1'b1);
			acc(8'h20, 1, 8'h01 << (4 + i));
			pulse(i);
			check(irq_n, 1'b1);
			acc(8'h07, 1, 0);
			check(rd, 8'h0e | (8'h01 << (4 + i)));
			acc(8'h27, 1, 8'h01 << (4 + i));
			acc(8'h20, 1, 8'h00);
		end
		acc(8'h50, 1, 8'h73);
		check(bank_indicator, 1'b0);
		acc(8'h50, 1, 8'h53);
		check(bank_indicator, 1'b1);
		check(st, 8'h0e);
		acc(8'hff, 0, 0);
		check(st, 8'h8e);
		acc(8'h20, 4, 32'h44332211);
		acc(8'h29, 4, 32'h88776655);
		acc(8'h00, 4, 0);
		check(rd, 32'h44332211);
		acc(8'h09, 4, 0);
		check(rd, 32'h88776655);
		acc(8'h50, 1, 8'h53);
		acc(8'h00, 1, 0);
		check(rd, 8'h00);
		check(bank_indicator, 1'b0);
		give_verdict();
	end
endmodule

// >>> test/rscr_host.sv
// Host serial master model for the register link, mode 0.
// Assumes the bench calls its tasks; sck stands low between frames.
`timescale 1ns/100ps
module rscr_host (
	output logic      spi_sck,
	output logic      spi_csn_n,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	initial begin
		spi_sck = 1'b0;
		spi_csn_n = 1'b1;
		spi_mosi = 1'b0;
	end
	task automatic sel();
		spi_csn_n <= 1'b0;
		#100;
	endtask
	// Released data line flips so no stale bit is read
	task automatic desel();
		#60;
		spi_csn_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		#100;
	endtask
	task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			spi_mosi <= b[i];
			#62.5 spi_sck <= 1'b1;
			r[i] = spi_miso;
			#62.5 spi_sck <= 1'b0;
		end
	endtask
endmodule

// >>> verilog/rscr_pkg.sv
// Constants for the radio serial register front end.
// Assumes a single core clock domain; serial pins are sampled in.
package rscr_pkg;
	localparam logic [4:0] ADDR_CFG    = 5'h00;
	localparam logic [4:0] ADDR_AA     = 5'h01;
	localparam logic [4:0] ADDR_RXEN   = 5'h02;
	localparam logic [4:0] ADDR_STATUS = 5'h07;
	localparam logic [4:0] B1_REV_LAST = 5'h08;
	localparam logic [4:0] B1_LAST     = 5'h0e;
	localparam logic [7:0] CFG_RST     = 8'h08;
	localparam logic [7:0] AA_RST      = 8'h3f;
	localparam logic [7:0] RXEN_RST    = 8'h03;
	localparam logic [7:0] CFG_WMASK   = 8'h7f;
	localparam logic [7:0] PIPE_WMASK  = 8'h3f;
	localparam int CFG_RX_MASK_POS     = 6;
	localparam int CFG_TX_MASK_POS     = 5;
	localparam int CFG_RT_MASK_POS     = 4;
	localparam int CFG_CRC_EN_POS      = 3;
	localparam int CFG_CRC_LEN_POS     = 2;
	localparam int CFG_PWR_POS         = 1;
	localparam int CFG_ROLE_POS        = 0;
	localparam int ST_BANK_POS         = 7;
	localparam logic [2:0] ST_PIPE_EMPTY = 3'h7;
	localparam logic [2:0] OP_READ     = 3'h0;
	localparam logic [2:0] OP_WRITE    = 3'h1;
	localparam logic [7:0] OP_ACTIVATE = 8'h50;
	localparam logic [7:0] BANK_TOGGLE = 8'h53;
	localparam logic [2:0] WORD_LAST   = 3'h3;
	localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
endpackage

// >>> verilog/rscr_spi_regs.sv
// Serial slave register front end: framing, two banks, first config regs.
// Assumes mode-0 serial master far slower than core_clk; events are
// one-cycle pulses from core_clk logic.
// Notes on behaviour
// - Low byte first, high bit first.
// - Status shifts out during command byte.
// - Bank one addresses 0-8 send high byte first.
// - Two banks; activate plus 0x53 toggles bank.
// - Status bit 7 shows current bank.
// - Bit 6 masks receive-ready from interrupt pin.
// - Bit 5 masks transmit-sent from interrupt pin.
// - Bit 4 masks retry-limit from interrupt pin.
// - CRC forced on by any auto-acknowledge bit.
// - Bit 2 picks one or two CRC bytes.
// - Bit 1 powers up, zero powers down.
// - Bit 0 picks receiver role; bit 7 zero.
// - Six auto-acknowledge pipe bits, reset ones.
// - Read is 000A AAAA, write 001A AAAA.
// - Activate opcode 0x50 takes one data byte.
// - Receive-ready flag set by event, write-one clears.
`timescale 1ns/100ps
module rscr_spi_regs (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       spi_sck,
	input  wire logic       spi_csn_n,
	input  wire logic       spi_mosi,
	output logic            spi_miso,
	output logic            spi_miso_oe,
	output logic            irq_n,
	input  wire logic       rx_ready_evt,
	input  wire logic       tx_sent_evt,
	input  wire logic       retry_limit_evt,
	output logic            crc_enable,
	output logic            crc_length_select,
	output logic            power_on_bit,
	output logic            primary_role_select,
	output logic [5:0]      auto_ack_pipes,
	output logic [5:0]      rx_pipe_enables,
	output logic            bank_indicator
);
	typedef struct packed {
		logic              sck_s1;
		logic              sck_s2;
		logic              sck_d;
		logic              csn_s1;
		logic              csn_s2;
		logic              csn_d;
		logic              mosi_s1;
		logic              mosi_s2;
		logic [2:0]        bitcnt;
		logic [2:0]        bytecnt;
		logic [7:0]        cmd;
		logic [7:0]        rx_sh;
		logic [7:0]        tx_sh;
		logic [7:0]        cfg;
		logic [7:0]        aa;
		logic [7:0]        rxen;
		logic [2:0]        flags;
		logic              bank;
		logic              irq_n;
		logic [14:0][31:0] b1;
	} rscr_state_t;

	logic        rst_s1_reg;
	logic        rst_n;
	rscr_state_t r;
	rscr_state_t n;
	logic        sck_rise;
	logic        sck_fall;
	logic        csn_fall;
	logic [7:0]  rx_byte;
	logic [7:0]  status;
	logic [7:0]  rdata;
	logic [2:0]  k;
	logic [1:0]  lane;
	logic [4:0]  addr;
	logic        act_hit;
	logic [2:0]  evt;
	logic [2:0]  masks;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	assign evt   = {rx_ready_evt, tx_sent_evt, retry_limit_evt};
	assign masks = {r.cfg[rscr_pkg::CFG_RX_MASK_POS],
		r.cfg[rscr_pkg::CFG_TX_MASK_POS],
		r.cfg[rscr_pkg::CFG_RT_MASK_POS]};
	// status byte with bank bit on top
	assign status = {r.bank, r.flags, rscr_pkg::ST_PIPE_EMPTY, 1'b0};

	always_comb begin
		n        = r;
		n.sck_s1 = spi_sck;
		n.sck_s2 = r.sck_s1;
		n.sck_d  = r.sck_s2;
		n.csn_s1 = spi_csn_n;
		n.csn_s2 = r.csn_s1;
		n.csn_d  = r.csn_s2;
		n.mosi_s1 = spi_mosi;
		n.mosi_s2 = r.mosi_s1;
		sck_rise = r.sck_s2 & ~r.sck_d & ~r.csn_s2;
		sck_fall = ~r.sck_s2 & r.sck_d & ~r.csn_s2;
		csn_fall = ~r.csn_s2 & r.csn_d;
		rx_byte  = {r.rx_sh[6:0], r.mosi_s2};
		addr     = r.cmd[4:0];
		k        = r.bytecnt - 3'h1;
		// reversed lanes in low bank one addresses
		lane = (addr <= rscr_pkg::B1_REV_LAST) ?
			2'(rscr_pkg::WORD_LAST - k) : k[1:0];
		rdata = 8'h00;
		if (r.cmd[7:5] == rscr_pkg::OP_READ && r.bytecnt != 3'h0) begin
			if (!r.bank) begin
				if (k == 3'h0) begin
					case (addr)
						rscr_pkg::ADDR_CFG:    rdata = r.cfg;
						rscr_pkg::ADDR_AA:     rdata = r.aa;
						rscr_pkg::ADDR_RXEN:   rdata = r.rxen;
						rscr_pkg::ADDR_STATUS: rdata = status;
						default:               rdata = 8'h00;
					endcase
				end
			end else if (addr <= rscr_pkg::B1_LAST &&
				k <= rscr_pkg::WORD_LAST) begin
				rdata = r.b1[addr][{lane, 3'b000} +: 8];
			end
		end
		act_hit = sck_rise && r.bitcnt == 3'h7 && r.bytecnt == 3'h1 &&
			r.cmd == rscr_pkg::OP_ACTIVATE &&
			rx_byte == rscr_pkg::BANK_TOGGLE;
		if (csn_fall) begin
			n.bitcnt  = 3'h0;
			n.bytecnt = 3'h0;
			n.tx_sh   = status;
		end else if (sck_rise) begin
			n.rx_sh  = rx_byte;
			n.bitcnt = r.bitcnt + 3'h1;
			if (r.bitcnt == 3'h7) begin
				if (r.bytecnt != rscr_pkg::BYTE_CNT_MAX)
					n.bytecnt = r.bytecnt + 3'h1;
				if (r.bytecnt == 3'h0) begin
					n.cmd = rx_byte;
				end else if (r.cmd[7:5] == rscr_pkg::OP_WRITE) begin
					if (!r.bank) begin
						if (k == 3'h0) begin
							case (addr)
								rscr_pkg::ADDR_CFG:
									n.cfg = rx_byte & rscr_pkg::CFG_WMASK;
								rscr_pkg::ADDR_AA:
									n.aa = rx_byte & rscr_pkg::PIPE_WMASK;
								rscr_pkg::ADDR_RXEN:
									n.rxen = rx_byte & rscr_pkg::PIPE_WMASK;
								rscr_pkg::ADDR_STATUS:
									n.flags = r.flags & ~rx_byte[6:4];
								default: n.cfg = r.cfg;
							endcase
						end
					end else if (addr <= rscr_pkg::B1_LAST &&
						k <= rscr_pkg::WORD_LAST) begin
						n.b1[addr][{lane, 3'b000} +: 8] = rx_byte;
					end
				end
			end
		end else if (sck_fall) begin
			// next byte loaded at byte boundary
			if (r.bitcnt == 3'h0)
				n.tx_sh = rdata;
			else
				n.tx_sh = {r.tx_sh[6:0], 1'b0};
		end
		if (act_hit)
			n.bank = ~r.bank;
		n.flags = n.flags | evt;
		n.irq_n = ~|(n.flags & ~masks);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{csn_s1: 1'b1, csn_s2: 1'b1, csn_d: 1'b1,
				cfg: rscr_pkg::CFG_RST, aa: rscr_pkg::AA_RST,
				rxen: rscr_pkg::RXEN_RST, irq_n: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign spi_miso    = r.tx_sh[7];
	assign spi_miso_oe = ~r.csn_s2;
	assign irq_n       = r.irq_n;
	assign crc_enable  = r.cfg[rscr_pkg::CFG_CRC_EN_POS] | (|r.aa[5:0]);
	assign crc_length_select   = r.cfg[rscr_pkg::CFG_CRC_LEN_POS];
	assign power_on_bit        = r.cfg[rscr_pkg::CFG_PWR_POS];
	assign primary_role_select = r.cfg[rscr_pkg::CFG_ROLE_POS];
	assign auto_ack_pipes      = r.aa[5:0];
	assign rx_pipe_enables     = r.rxen[5:0];
	assign bank_indicator      = r.bank;

	chk_crc_forced: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(|auto_ack_pipes) |-> crc_enable)
		else $error("crc not forced by auto-ack");
	chk_irq_unmasked: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(rx_ready_evt && !masks[2]) |=> !irq_n)
		else $error("unmasked rx event left irq high");
	chk_cfg_reserved: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		r.cfg[7] == 1'b0)
		else $error("config reserved bit set");
	chk_aa_reserved: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		r.aa[7:6] == 2'b00 && r.rxen[7:6] == 2'b00)
		else $error("pipe reserved bits set");
	chk_event_sets: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		rx_ready_evt |=> r.flags[2])
		else $error("rx ready flag not set");
	chk_status_bank: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(csn_fall && !act_hit) |=> spi_miso == $past(r.bank))
		else $error("status msb is not the bank");
	chk_bank_toggle: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(r.bank != n.bank) |-> act_hit)
		else $error("bank changed without activate");
	chk_frame_restart: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		csn_fall |=> (r.bitcnt == 3'h0 && r.bytecnt == 3'h0))
		else $error("counters not restarted on select");
	chk_rev_first: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(sck_rise && !csn_fall && r.bitcnt == 3'h7 &&
		r.bytecnt == 3'h1 && r.bank &&
		r.cmd[7:5] == rscr_pkg::OP_WRITE &&
		addr <= rscr_pkg::B1_REV_LAST)
		|=> r.b1[$past(addr)][31:24] == $past(rx_byte))
		else $error("bank one first byte not in top lane");
endmodule
